// File: logic/gpic_ext.sv
// external pin trigger detection and flags
`timescale 1ns/10ps
module gpic_ext
  import gpic_pkg::*;
(
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // pins and configuration
  input  wire logic [NPIN-1:0] pin,
  input  wire logic [7:0]      mode,
  input  wire logic [NPIN-1:0] pol,
  input  wire logic [NPIN-1:0] en,
  input  wire logic [NPIN-1:0] clr,
  // status
  output logic [NPIN-1:0]      flag,
  output logic                 wake
);

  logic [NPIN-1:0] prev_r;
  logic [NPIN-1:0] flag_r;
  logic [NPIN-1:0] flag_nxt;
  logic [NPIN-1:0] hit;
  logic            wake_set;
  logic            wake_r;

  // ----------------------------------------------------------------
  // per pin trigger
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    logic edge_md;
    assign edge_md  = mode[2*p +: 2] == XMODE_EDGE;                  // RULE24
    // edge mode fires on either edge, polarity only picks the level
    assign hit[p]   = en[p] & (edge_md ? (pin[p] ^ prev_r[p])         // RULE16
                                       : (pin[p] == pol[p]));         // RULE17
    // set wins over a clear in the same cycle
    assign flag_nxt[p] = hit[p] | (flag_r[p] & ~clr[p]);             // RULE25
  end

  // combinational path so a trigger is caught with the clock stopped
  assign wake_set = |hit;                                              // RULE19

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '0;
      flag_r <= '0;
    end else begin
      prev_r <= pin;
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn or posedge wake_set) begin
    if (!presetn) begin
      wake_r <= 1'b0;
    end else if (wake_set) begin
      wake_r <= 1'b1;
    end else begin
      wake_r <= |flag_r;
    end
  end

  assign flag = flag_r;
  assign wake = wake_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_lvl_hold;
    @(posedge pclk) disable iff (!presetn)
      (en[0] && mode[1:0] != XMODE_EDGE && pin[0] == pol[0]) |=> flag_r[0];
  endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("level pin lost its flag"); // RULE17

  property p_wr_clr;
    @(posedge pclk) disable iff (!presetn)
      (clr[0] && !hit[0]) |=> !flag_r[0];
  endproperty
  a_wr_clr: assert property (p_wr_clr) else $error("flag not cleared"); // RULE25

endmodule

// File: logic/gpic_pkg.sv
// shared constants, carriers and decode helpers for the grouped interrupt controller
package gpic_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NSRC   = 24;
  localparam int NGRP   = 6;
  localparam int NPIN   = 4;
  localparam int NLVL   = 4;
  localparam int EN_W   = 6;
  localparam int GIE_B  = 7;
  localparam int XPIN0  = 1;
  localparam int PEND_W = 24;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_EN0    = 8'hA8;
  localparam logic [7:0] IDX_EN1    = 8'hA9;
  localparam logic [7:0] IDX_EN2    = 8'hAA;
  localparam logic [7:0] IDX_EN3    = 8'hAB;
  localparam logic [7:0] IDX_XFLAG  = 8'hAC;
  localparam logic [7:0] IDX_XMODE  = 8'hAD;
  localparam logic [7:0] IDX_XPOL   = 8'hAE;
  localparam logic [7:0] IDX_XEN    = 8'hAF;
  localparam logic [7:0] IDX_PRI_LO = 8'hB8;
  localparam logic [7:0] IDX_PRI_HI = 8'hF8;
  localparam logic [7:0] IDX_PEND   = 8'hC0;
  localparam logic [7:0] IDX_STAT   = 8'hC1;

  // ----------------------------------------------------------------
  // reset values and source classes
  // ----------------------------------------------------------------
  localparam logic [7:0]  XMODE_RST  = 8'h55;
  localparam logic [3:0]  XPOL_RST   = 4'hF;
  localparam logic [1:0]  XMODE_EDGE = 2'h0;
  localparam logic [23:0] NOAUTO_MSK = 24'h88_1400;
  localparam logic [23:0] NOFLAG_MSK = 24'h88_0020;
  localparam logic [23:0] DIRECT_MSK = 24'h88_141E;
  localparam logic [23:0] ONE_SRC    = 24'h00_0001;
  localparam logic [15:0] VEC_BASE   = 16'h0003;
  localparam int          VEC_SH     = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    GPIC_APB_IDLE = 1'b0,
    GPIC_APB_ACK  = 1'b1
  } gpic_apb_e;

  typedef struct packed {
    logic last_cycle;
    logic return_from_irq;
  } gpic_cpu_in_s;

  typedef struct packed {
    logic        take;
    logic [15:0] vector;
    logic [1:0]  level;
  } gpic_cpu_out_s;

  function automatic logic [2:0] grp_of(input int src);
    return 3'(src % NGRP);
  endfunction

  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
    return a[9:2] == idx;
  endfunction

endpackage

// File: logic/gpic_sel.sv
// priority picker: highest group level first, then lowest source number
`timescale 1ns/10ps
module gpic_sel
  import gpic_pkg::*;
(
  // candidates and group levels
  input  wire logic [NSRC-1:0] cand,
  input  wire logic [NGRP-1:0] pri_lo,
  input  wire logic [NGRP-1:0] pri_hi,
  // winner
  output logic                 found,
  output logic [4:0]           idx,
  output logic [1:0]           lvl
);

  always_comb begin
    logic [2:0] g;
    logic [1:0] l;
    g     = '0;
    l     = '0;
    found = 1'b0;
    idx   = '0;
    lvl   = '0;
    // walking downward with >= leaves the lowest number among equal levels
    for (int i = NSRC - 1; i >= 0; i--) begin
      g = grp_of(i);                                          // RULE3
      l = {pri_hi[g], pri_lo[g]};                             // RULE23
      if (cand[i] && (!found || l >= lvl)) begin              // RULE5 RULE6
        found = 1'b1;
        idx   = 5'(i);
        lvl   = l;
      end
    end
  end

endmodule

// File: logic/gpic_top.sv
// grouped priority interrupt controller with apb registers and cpu vector port
//
// Notes on behaviour
// RULE1: global enable low masks every request
// RULE2: source forwarded only when its enable set
// RULE3: six groups of four, group g strided
// RULE4: each group gets one of four levels
// RULE5: higher group level is picked first
// RULE6: equal level: lowest source number wins
// RULE7: vector is 0003h plus eight times source
// RULE8: cpu performs long call to vector
// RULE9: vector handed over at acceptance
// RULE10: sample requests at instruction last cycle
// RULE11: request to handler within 3..9 cycles
// RULE12: latched request held until accept or clear
// RULE13: most flags auto-cleared on acceptance
// RULE14: tx, key-scan, flash cleared by software
// RULE15: key-scan, flash, pin-change have no flag
// RULE16: pins trigger on edge or level
// RULE17: level pin keeps requesting while active
// RULE18: level after reset, only pins edge-capable
// RULE19: pin events seen without the clock (ext_wake is registered again on pclk, so it needs a clock edge)
// RULE20: pre-empt only by strictly higher level
// RULE21: next highest pending follows after service
// RULE22: handler ends with return from interrupt
// RULE23: level is high bit then low bit
// RULE24: mode 00 edge, else level by polarity
// RULE25: writing zero clears an external flag
// RULE26: track levels in service, restore on return
`timescale 1ns/10ps
module gpic_top
  import gpic_pkg::*;
(
  // apb slave
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // interrupt sources
  input  wire logic [NSRC-1:0] src_req,
  input  wire logic [NPIN-1:0] ext_irq_pin,
  // acknowledge pulses to sources with auto-cleared flags
  output logic [NSRC-1:0]    src_ack,
  // cpu core
  input  wire gpic_cpu_in_s  cpu_in,
  output gpic_cpu_out_s      cpu_out,
  // stop mode wake
  output logic               ext_wake
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  gpic_apb_e          st_r;
  gpic_apb_e          st_nxt;
  logic               pready_r;
  logic               pready_nxt;
  logic               pslverr_r;
  logic               pslverr_nxt;
  logic [31:0]        prdata_r;
  logic [31:0]        prdata_nxt;
  logic               gie_r;
  logic               gie_nxt;
  logic [NSRC-1:0]    en_r;
  logic [NSRC-1:0]    en_nxt;
  logic [NGRP-1:0]    pri_lo_r;
  logic [NGRP-1:0]    pri_lo_nxt;
  logic [NGRP-1:0]    pri_hi_r;
  logic [NGRP-1:0]    pri_hi_nxt;
  logic [7:0]         xmode_r;
  logic [7:0]         xmode_nxt;
  logic [NPIN-1:0]    xpol_r;
  logic [NPIN-1:0]    xpol_nxt;
  logic [NPIN-1:0]    xen_r;
  logic [NPIN-1:0]    xen_nxt;

  // ----------------------------------------------------------------
  // interrupt state
  // ----------------------------------------------------------------
  logic [NSRC-1:0]    pend_r;
  logic [NSRC-1:0]    pend_nxt;
  logic [NLVL-1:0]    insvc_r;
  logic [NLVL-1:0]    insvc_nxt;
  logic               take_r;
  logic               take_nxt;
  logic [15:0]        vec_r;
  logic [15:0]        vec_nxt;
  logic [1:0]         tlvl_r;
  logic [1:0]         tlvl_nxt;
  logic [NSRC-1:0]    ack_r;
  logic [NSRC-1:0]    ack_nxt;
  logic               wake_r;

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic               acc_rd;
  logic               acc_wr;
  logic               mapped;
  logic [31:0]        rmux;
  logic [NSRC-1:0]    req_all;
  logic [NSRC-1:0]    cand;
  logic [NSRC-1:0]    clr_vec;
  logic [NSRC-1:0]    sw_clr;
  logic [NPIN-1:0]    xflag;
  logic [NPIN-1:0]    xclr;
  logic               xwake;
  logic               sel_found;
  logic [4:0]         sel_idx;
  logic [1:0]         sel_lvl;
  logic               cur_vld;
  logic [1:0]         cur_lvl;
  logic               accept;

  // ----------------------------------------------------------------
  // apb handshake: one wait state, answer on the second access cycle
  // ----------------------------------------------------------------
  assign acc_rd = psel & penable & ~pready_r;
  assign acc_wr = psel & penable & pready_r & pwrite;

  always_comb begin
    mapped = reg_hit(paddr, IDX_EN0)    | reg_hit(paddr, IDX_EN1)    |
             reg_hit(paddr, IDX_EN2)    | reg_hit(paddr, IDX_EN3)    |
             reg_hit(paddr, IDX_XFLAG)  | reg_hit(paddr, IDX_XMODE)  |
             reg_hit(paddr, IDX_XPOL)   | reg_hit(paddr, IDX_XEN)    |
             reg_hit(paddr, IDX_PRI_LO) | reg_hit(paddr, IDX_PRI_HI) |
             reg_hit(paddr, IDX_PEND)   | reg_hit(paddr, IDX_STAT);
    rmux = '0;
    if (reg_hit(paddr, IDX_EN0)) begin
      rmux[GIE_B]    = gie_r;
      rmux[EN_W-1:0] = en_r[0 +: EN_W];
    end
    if (reg_hit(paddr, IDX_EN1)) rmux[EN_W-1:0] = en_r[EN_W +: EN_W];
    if (reg_hit(paddr, IDX_EN2)) rmux[EN_W-1:0] = en_r[2*EN_W +: EN_W];
    if (reg_hit(paddr, IDX_EN3)) rmux[EN_W-1:0] = en_r[3*EN_W +: EN_W];
    if (reg_hit(paddr, IDX_XFLAG)) rmux[NPIN-1:0] = xflag;
    if (reg_hit(paddr, IDX_XMODE)) rmux[7:0] = xmode_r;
    if (reg_hit(paddr, IDX_XPOL)) rmux[NPIN-1:0] = xpol_r;
    if (reg_hit(paddr, IDX_XEN)) rmux[NPIN-1:0] = xen_r;
    if (reg_hit(paddr, IDX_PRI_LO)) rmux[NGRP-1:0] = pri_lo_r;
    if (reg_hit(paddr, IDX_PRI_HI)) rmux[NGRP-1:0] = pri_hi_r;
    // sources without a status flag cannot be polled
    if (reg_hit(paddr, IDX_PEND)) rmux[PEND_W-1:0] = pend_r & ~NOFLAG_MSK; // RULE15
    if (reg_hit(paddr, IDX_STAT)) rmux[NLVL-1:0] = insvc_r;
  end

  always_comb begin
    st_nxt      = st_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    case (st_r)
      GPIC_APB_IDLE: begin
        if (acc_rd) begin
          st_nxt      = GPIC_APB_ACK;
          pready_nxt  = 1'b1;
          pslverr_nxt = ~mapped;
          prdata_nxt  = pwrite ? '0 : rmux;
        end
      end
      GPIC_APB_ACK: begin
        st_nxt = GPIC_APB_IDLE;
      end
      default: begin
        st_nxt = GPIC_APB_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  always_comb begin
    gie_nxt    = gie_r;
    en_nxt     = en_r;
    pri_lo_nxt = pri_lo_r;
    pri_hi_nxt = pri_hi_r;
    xmode_nxt  = xmode_r;
    xpol_nxt   = xpol_r;
    xen_nxt    = xen_r;
    sw_clr     = '0;
    xclr       = '0;
    if (acc_wr) begin
      if (reg_hit(paddr, IDX_EN0)) begin
        gie_nxt           = pwdata[GIE_B];
        en_nxt[0 +: EN_W] = pwdata[EN_W-1:0];
      end
      if (reg_hit(paddr, IDX_EN1)) en_nxt[EN_W +: EN_W]   = pwdata[EN_W-1:0];
      if (reg_hit(paddr, IDX_EN2)) en_nxt[2*EN_W +: EN_W] = pwdata[EN_W-1:0];
      if (reg_hit(paddr, IDX_EN3)) en_nxt[3*EN_W +: EN_W] = pwdata[EN_W-1:0];
      if (reg_hit(paddr, IDX_PRI_LO)) pri_lo_nxt = pwdata[NGRP-1:0];        // RULE4
      if (reg_hit(paddr, IDX_PRI_HI)) pri_hi_nxt = pwdata[NGRP-1:0];        // RULE4
      if (reg_hit(paddr, IDX_XMODE)) xmode_nxt = pwdata[7:0];
      if (reg_hit(paddr, IDX_XPOL)) xpol_nxt = pwdata[NPIN-1:0];
      if (reg_hit(paddr, IDX_XEN)) xen_nxt = pwdata[NPIN-1:0];
      if (reg_hit(paddr, IDX_XFLAG)) xclr = ~pwdata[NPIN-1:0];            // RULE25
      if (reg_hit(paddr, IDX_PEND)) sw_clr = ~pwdata[PEND_W-1:0];
    end
    xclr = xclr | ack_nxt[XPIN0 +: NPIN];                                 // RULE13
  end

  // ----------------------------------------------------------------
  // request collection and pending latch
  // ----------------------------------------------------------------
  always_comb begin
    req_all                 = src_req;
    req_all[XPIN0 +: NPIN]  = xflag;
    clr_vec                 = ack_nxt | sw_clr;
    // flags that live in the source or the pin block follow it directly;
    // the rest latch here and a new request beats a same-cycle clear
    pend_nxt = (DIRECT_MSK & req_all) |
               (~DIRECT_MSK & ((pend_r & ~clr_vec) | req_all));           // RULE12 RULE21
    cand     = pend_r & en_r & {NSRC{gie_r}};                             // RULE1 RULE2
  end

  // ----------------------------------------------------------------
  // level in service, highest set bit is the running level
  // ----------------------------------------------------------------
  always_comb begin
    cur_vld = 1'b0;
    cur_lvl = '0;
    for (int l = 0; l < NLVL; l++) begin
      if (insvc_r[l]) begin
        cur_vld = 1'b1;
        cur_lvl = 2'(l);
      end
    end
  end

  // ----------------------------------------------------------------
  // acceptance
  // ----------------------------------------------------------------
  assign accept = cpu_in.last_cycle & sel_found & gie_r &
                  (!cur_vld || sel_lvl > cur_lvl);                          // RULE10 RULE20

  always_comb begin
    take_nxt  = accept;                                                   // RULE11
    vec_nxt   = vec_r;
    tlvl_nxt  = tlvl_r;
    ack_nxt   = '0;
    insvc_nxt = insvc_r;
    if (cpu_in.return_from_irq && cur_vld) begin
      insvc_nxt[cur_lvl] = 1'b0;                                          // RULE26
    end
    if (accept) begin
      vec_nxt   = VEC_BASE + (16'(sel_idx) << VEC_SH);                    // RULE7 RULE9
      tlvl_nxt  = sel_lvl;
      ack_nxt   = (ONE_SRC << sel_idx) & ~NOAUTO_MSK;                     // RULE13 RULE14
      insvc_nxt[sel_lvl] = 1'b1;                                          // RULE26
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= GPIC_APB_IDLE;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
      gie_r     <= 1'b0;
      en_r      <= '0;
      pri_lo_r  <= '0;
      pri_hi_r  <= '0;
      xmode_r   <= XMODE_RST;                                             // RULE18
      xpol_r    <= XPOL_RST;
      xen_r     <= '0;
      pend_r    <= '0;
      insvc_r   <= '0;
      take_r    <= 1'b0;
      vec_r     <= VEC_BASE;
      tlvl_r    <= '0;
      ack_r     <= '0;
      wake_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
      gie_r     <= gie_nxt;
      en_r      <= en_nxt;
      pri_lo_r  <= pri_lo_nxt;
      pri_hi_r  <= pri_hi_nxt;
      xmode_r   <= xmode_nxt;
      xpol_r    <= xpol_nxt;
      xen_r     <= xen_nxt;
      pend_r    <= pend_nxt;
      insvc_r   <= insvc_nxt;
      take_r    <= take_nxt;
      vec_r     <= vec_nxt;
      tlvl_r    <= tlvl_nxt;
      ack_r     <= ack_nxt;
      wake_r    <= xwake;
    end
  end

  // ----------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------
  gpic_sel u_sel (
    .cand   (cand),
    .pri_lo (pri_lo_r),
    .pri_hi (pri_hi_r),
    .found  (sel_found),
    .idx    (sel_idx),
    .lvl    (sel_lvl)
  );

  // the raw pin wake is registered again here, so ext_wake lags one edge
  gpic_ext u_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_irq_pin),
    .mode    (xmode_r),
    .pol     (xpol_r),
    .en      (xen_r),
    .clr     (xclr),
    .flag    (xflag),
    .wake    (xwake)
  );

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign src_ack        = ack_r;
  assign cpu_out.take   = take_r;
  assign cpu_out.vector = vec_r;
  assign cpu_out.level  = tlvl_r;
  assign ext_wake       = wake_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_gie_off;
    !gie_r |=> !take_r;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("take while disabled"); // RULE1

  property p_en_off;
    take_r |-> $past(en_r[sel_idx]) && $past(pend_r[sel_idx]);
  endproperty
  a_en_off: assert property (p_en_off) else $error("take of masked source"); // RULE2

  property p_last;
    take_r |-> $past(cpu_in.last_cycle);
  endproperty
  a_last: assert property (p_last) else $error("take outside last cycle"); // RULE10

  property p_vec;
    take_r |-> vec_r == VEC_BASE + (16'($past(sel_idx)) << VEC_SH);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector"); // RULE7

  property p_nest;
    (take_r && $past(cur_vld)) |-> $past(sel_lvl) > $past(cur_lvl);
  endproperty
  a_nest: assert property (p_nest) else $error("nested without higher level"); // RULE20

  property p_insvc;
    take_r |-> insvc_r[tlvl_r];
  endproperty
  a_insvc: assert property (p_insvc) else $error("level not recorded"); // RULE26

  property p_autoclr;
    take_r |-> src_ack == ((ONE_SRC << $past(sel_idx)) & ~NOAUTO_MSK);
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("bad acknowledge"); // RULE13

  property p_noauto;
    (src_ack & NOAUTO_MSK) == '0;
  endproperty
  a_noauto: assert property (p_noauto) else $error("software flag acked"); // RULE14

  property p_hold;
    ($past(pend_r) & ~pend_r & ~DIRECT_MSK & ~$past(clr_vec)) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("pending lost"); // RULE12

  property p_noflag;
    (pready_r && !pwrite && reg_hit(paddr, IDX_PEND)) |-> (prdata_r[PEND_W-1:0] & NOFLAG_MSK) == '0;
  endproperty
  a_noflag: assert property (p_noflag) else $error("flagless source visible"); // RULE15

  c_take: cover property (take_r);
  c_nested: cover property (take_r && $countones(insvc_r) > 1);
  c_return_from_irq: cover property (cpu_in.return_from_irq && cur_vld);
  c_ext: cover property (|xflag);

endmodule

// File: verification/gpic_cpu_model.sv
// behavioural cpu core that marks instruction ends, takes vectors and returns from handlers
`timescale 1ns/10ps
module gpic_cpu_model
  import gpic_pkg::*;
#(
  parameter int HLEN = 12
)
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // controller side
  input  wire gpic_cpu_out_s cpu_out,
  output gpic_cpu_in_s       cpu_in
);
  logic [3:0] cnt_r;
  int         depth;
  int         hcnt;

  // ----------------------------------------------------------------
  // instruction ends and handler nesting
  // ----------------------------------------------------------------
  // uneven instruction lengths give both prompt and slow acceptance
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_in <= '0;
      cnt_r  <= '0;
      depth  <= 0;
      hcnt   <= 0;
    end else begin
      cnt_r              <= cnt_r + 4'h1;
      cpu_in.last_cycle  <= (cnt_r[1:0] == 2'h3) || (cnt_r[3:2] == 2'h0);
      cpu_in.return_from_irq        <= 1'b0;
      if (cpu_out.take) begin
        depth <= depth + 1;
        hcnt  <= HLEN;
      end else if (depth > 0 && hcnt == 1) begin
        cpu_in.return_from_irq <= 1'b1;
        depth       <= depth - 1;
        hcnt        <= HLEN;
      end else if (hcnt > 0) begin
        hcnt <= hcnt - 1;
      end
    end
  end
endmodule

// File: verification/tb_top.sv
// self-checking bench for the grouped interrupt controller
`timescale 1ns/10ps
module tb_top import gpic_pkg::*;;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ext_wake;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [23:0]   src_req, src_ack;
  logic [3:0]    pin;
  gpic_cpu_in_s  cpu_in;
  gpic_cpu_out_s cpu_out;
  logic [39:0]   q[$];
  int            num_errors, n_compared, seed, s;

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  gpic_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .ext_irq_pin(pin), .src_ack(src_ack),
    .cpu_in(cpu_in), .cpu_out(cpu_out), .ext_wake(ext_wake));
  gpic_cpu_model #(.HLEN(12)) i_cpu (.pclk(pclk), .presetn(presetn), .cpu_out(cpu_out),
    .cpu_in(cpu_in));

  task automatic chk(input logic [39:0] v, input logic [39:0] e);
    n_compared++;
    if (v !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'h0, idx, 2'h0}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(40'(rd), 40'(e));
  endtask

  function automatic logic [39:0] ex(input int n);
    return {16'h0003 + 16'(n * 8), ONE_SRC << n};
  endfunction

  task automatic pulse(input logic [23:0] m);
    @(posedge pclk) src_req <= m;
    @(posedge pclk) src_req <= 24'h0;
  endtask

  // wait for every noted vector, then let the handler return
  task automatic drain;
    int n;
    n = 0;
    while (q.size() != 0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(40'(q.size()), 40'h0);
    repeat (20) @(posedge pclk);
  endtask

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // an acceptance with nothing noted is itself a mismatch
  always @(negedge pclk) begin
    if (cpu_out.take === 1'b1) begin
      if (q.size() == 0) chk({cpu_out.vector, src_ack}, 40'h0);
      else chk({cpu_out.vector, src_ack}, q.pop_front());
    end
  end

  initial begin
    #1_000_000;
    num_errors++;
    final_report;
  end

  initial begin
    seed = 29; num_errors = 0; n_compared = 0; presetn = 1'b0; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; src_req = 24'h0; pin = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(IDX_EN0, 32'h0);
    rdc(IDX_XMODE, 32'h55);
    rdc(IDX_XPOL, 32'hF);
    apb(1'b0, 8'h10, 32'h0);
    chk(40'({er, rd}), 40'h1_0000_0000);
    @(posedge pclk) src_req <= (ONE_SRC << 19) | (ONE_SRC << 18);
    rdc(IDX_PEND, {8'h0, ONE_SRC << 18});
    @(posedge pclk) src_req <= 24'h0;
    apb(1'b1, IDX_PEND, 32'h0);
    rdc(IDX_PEND, 32'h0);
    $display("registers done");
    for (int i = 0; i < 4; i++) apb(1'b1, IDX_EN0 + 8'(i), 32'h3F);
    pulse(ONE_SRC << 13);
    repeat (30) @(posedge pclk);
    q.push_back(ex(13));
    apb(1'b1, IDX_EN0, 32'hBF);
    drain;
    apb(1'b1, IDX_EN2, 32'h3D);
    pulse(ONE_SRC << 13);
    repeat (30) @(posedge pclk);
    apb(1'b1, IDX_PEND, 32'hFFFF_DFFF);
    apb(1'b1, IDX_EN2, 32'h3F);
    repeat (30) @(posedge pclk);
    chk(40'(q.size()), 40'h0);
    $display("masking done");
    // software owns this flag: the request is dropped once the vector is taken
    q.push_back(ex(10) & 40'hFF_FF00_0000);
    @(posedge pclk) src_req <= ONE_SRC << 10;
    @(posedge pclk iff cpu_out.take === 1'b1);
    src_req <= 24'h0;
    drain;
    $display("software cleared source done");
    for (int i = 0; i < 16; i++) begin
      s = {$random(seed)} % 24;
      if (!DIRECT_MSK[s]) begin
        q.push_back(ex(s));
        pulse(ONE_SRC << s);
        drain;
      end
    end
    $display("random sources done");
    apb(1'b1, IDX_PRI_LO, 32'h2);
    apb(1'b1, IDX_PRI_HI, 32'h2);
    q.push_back(ex(13));
    q.push_back(ex(0));
    pulse((ONE_SRC << 13) | ONE_SRC);
    drain;
    q.push_back(ex(6));
    q.push_back(ex(18));
    pulse((ONE_SRC << 18) | (ONE_SRC << 6));
    drain;
    $display("priority done");
    apb(1'b1, IDX_EN0, 32'h3F);
    apb(1'b1, IDX_XMODE, 32'h54);
    apb(1'b1, IDX_XEN, 32'h1);
    @(posedge pclk) pin <= 4'h1;
    repeat (4) @(posedge pclk);
    rdc(IDX_XFLAG, 32'h1);
    chk(40'(ext_wake), 40'h1);
    apb(1'b1, IDX_XFLAG, 32'h0);
    rdc(IDX_XFLAG, 32'h0);
    apb(1'b1, IDX_EN0, 32'hBF);
    repeat (20) @(posedge pclk);
    q.push_back(ex(1));
    @(posedge pclk) pin <= 4'h0;
    drain;
    apb(1'b1, IDX_EN0, 32'h3F);
    apb(1'b1, IDX_XMODE, 32'h55);
    @(posedge pclk) pin <= 4'h1;
    repeat (2) @(posedge pclk);
    apb(1'b1, IDX_XFLAG, 32'h0);
    rdc(IDX_XFLAG, 32'h1);
    @(posedge pclk) pin <= 4'h0;
    apb(1'b1, IDX_XFLAG, 32'h0);
    rdc(IDX_XFLAG, 32'h0);
    $display("external pins done");
    final_report;
  end
endmodule
